// file: rtl/cssel_pkg.sv
/*
 * cssel_pkg: constants, types and register map of the clock source
 * selection and start-up sequencer.
 * assumes: included by the single design module cssel_top and by the bench.
 */
package cssel_pkg;

    // ----------------------------------------------------------------
    // fuse codes (1 = unprogrammed, 0 = programmed)
    // ----------------------------------------------------------------
    localparam logic [3:0] SEL_LF_FAST  = 4'h6;  // low-freq crystal, short wake
    localparam logic [3:0] SEL_LF_SLOW  = 4'h7;  // low-freq crystal, long wake
    localparam logic [3:0] SEL_RC       = 4'h2;  // calibrated rc oscillator
    localparam logic [3:0] SEL_EXT      = 4'h0;  // external clock input pin
    localparam logic [1:0] STARTUP_SHORT = 2'h0; // no watchdog delay
    localparam logic [1:0] STARTUP_MID   = 2'h1; // 4.1 ms watchdog delay
    localparam logic [1:0] STARTUP_LONG  = 2'h2; // 65 ms watchdog delay
    localparam logic       FUSE_PROG    = 1'b0;  // programmed fuse level

    // ----------------------------------------------------------------
    // cycle counts and prescaler codes
    // ----------------------------------------------------------------
    localparam logic [16:0] LF_RST_CYC   = 17'h00004; // 4 source cycles
    localparam logic [16:0] RC_RST_CYC   = 17'h0000e; // 14 source cycles
    localparam logic [16:0] LF_WAKE_CYC  = 17'h00400; // 1K source cycles
    localparam logic [16:0] RC_WAKE_CYC  = 17'h00006; // 6 source cycles
    localparam logic [16:0] WDT_MID_CYC  = 17'h01000; // 4,096 watchdog cycles
    localparam logic [3:0]  DIV8_CODE    = 4'h3;      // prescaler code for /8
    localparam logic [3:0]  DIV1_CODE    = 4'h0;      // prescaler code for /1

    // ----------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFS_TRIM     = 8'h00;     // rc_trim_register, rw
    localparam logic [7:0]  OFS_CTRL     = 8'h04;     // bit0: enter power-down
    localparam logic [7:0]  OFS_STATUS   = 8'h08;     // read-only state
    localparam int          CTRL_SLEEP_B = 0;         // sleep request bit
    localparam logic [31:0] RD_ZERO      = 32'h00000000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] clock_source_select_fuses;
        logic [1:0] startup_time_fuses;
        logic       div8_default_fuse;
    } cssel_fuse_s;

    typedef enum logic [1:0] {
        SRC_LF  = 2'b00,
        SRC_RC  = 2'b01,
        SRC_EXT = 2'b10
    } cssel_src_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SRC   = 3'b001,
        ST_WDT   = 3'b010,
        ST_RUN   = 3'b011,
        ST_SLEEP = 3'b100,
        ST_WAKE  = 3'b101
    } cssel_state_e;

endpackage

// file: rtl/cssel_top.sv
/*
 * cssel_top: fuse-driven clock source selection, reset and wake-up
 * start-up delays, rc trim register and default prescaler code.
 * assumes: CLK_I at 20 MHz; oscillator levels and fuses arrive from outside
 * the clock domain; apb master on the same clock.
 */
// The placing of the registers and the APB slave port are this design's own decisions.
// Notes on behaviour
// - fuse codes 0110/0111 select low-frequency crystal
// - lf crystal reset delay 4 cycles plus watchdog
// - lf crystal wake waits 1K or 32K
// - code 0010 selects internal rc oscillator
// - reset loads factory trim into trim register
// - software may rewrite trim register anytime
// - watchdog oscillator keeps ticking watchdog and timeout
// - rc wake 6 cycles, reset 14 plus watchdog
// - programmed div8 fuse presets divide by eight
// - shipped default is rc, long delay, div8
// - code 0000 takes external clock input pin
// - external clock wake 6, reset 14 plus watchdog
// - fuse bit 1 unprogrammed, 0 programmed
// - watchdog delays count 4096 or 65536 cycles
// - wake count uses selected source's own cycles
`timescale 1ns/1ps
`default_nettype none

module cssel_top
#(
    parameter logic [16:0] LF_WAKE_LONG_CYC = 17'h08000, // 32K source cycles
    parameter logic [16:0] WDT_LONG_CYC     = 17'h10000  // 65,536 watchdog cycles
)
(
    // clock, reset, enable
    input  wire logic                  CLK_I,
    input  wire logic                  SYS_RST_I,
    input  wire logic                  CE_I,
    // fuses and factory calibration
    input  wire cssel_pkg::cssel_fuse_s FUSE_I,
    input  wire logic [7:0]            FACTORY_TRIM_I,
    // oscillator levels and wake request
    input  wire logic                  LF_OSC_I,
    input  wire logic                  RC_OSC_I,
    input  wire logic                  CLOCK_INPUT_PIN_I,
    input  wire logic                  WDT_OSC_I,
    input  wire logic                  WAKE_I,
    // apb slave
    input  wire logic                  PSEL_I,
    input  wire logic                  PENABLE_I,
    input  wire logic                  PWRITE_I,
    input  wire logic [7:0]            PADDR_I,
    input  wire logic [31:0]           PWDATA_I,
    output logic [31:0]                PRDATA_O,
    output logic                       PREADY_O,
    output logic                       PSLVERR_O,
    // clock control results
    output cssel_pkg::cssel_src_e      SRC_SEL_O,
    output logic [3:0]                 DIV_INIT_O,
    output logic [7:0]                 TRIM_O,
    output logic                       WDT_TICK_O,
    output logic                       RUN_O
);
    import cssel_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    cssel_state_e state_q;             // sequencer state
    cssel_state_e state_d;             // next sequencer state
    cssel_src_e   src_q;               // selected source
    cssel_fuse_s  fz_s1_q;             // fuse synchroniser, first stage
    cssel_fuse_s  fz_q;                // fuses, synchronised
    logic [4:0]   osc_s1_q;            // level synchroniser, first stage
    logic [4:0]   osc_s2_q;            // level synchroniser, second stage
    logic [3:0]   osc_d_q;             // delayed lf, rc, ext and watchdog levels
    logic [16:0]  cnt_q;               // shared start-up counter
    logic [1:0]   sut_q;               // captured start-up code
    logic         fuse_err_q;          // reserved code seen at capture
    logic [3:0]   osc_rise;            // rising edges of the four levels, synced
    logic         src_tick;            // rising edge of selected source
    logic         wdt_tick;            // rising edge of watchdog osc
    logic         wake_lvl;            // wake request, synced
    logic         sleep_req;           // software asks for power-down
    logic         apb_acc;             // access phase completes this edge
    logic         apb_wr;              // write completes this edge
    logic         addr_ok;             // address is mapped
    logic [16:0]  rst_tgt;             // reset source-cycle target
    logic [16:0]  wake_tgt;            // wake source-cycle target
    logic [16:0]  wdt_tgt;             // watchdog cycle target

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // source cycles counted after reset, per source
    function automatic logic [16:0] rst_cycles(input cssel_src_e s);
        rst_cycles = (s == SRC_LF) ? LF_RST_CYC : RC_RST_CYC;
    endfunction

    // source cycles counted on wake, per select code
    function automatic logic [16:0] wake_cycles(input logic [3:0] c);
        unique case (c)
            SEL_LF_FAST: wake_cycles = LF_WAKE_CYC;
            SEL_LF_SLOW: wake_cycles = LF_WAKE_LONG_CYC;
            default:     wake_cycles = RC_WAKE_CYC;
        endcase
    endfunction

    // watchdog cycles added after the source count; reserved acts as long
    function automatic logic [16:0] wdt_cycles(input logic [1:0] s);
        unique case (s)
            STARTUP_SHORT: wdt_cycles = 17'h00000;
            STARTUP_MID:   wdt_cycles = WDT_MID_CYC;
            default:   wdt_cycles = WDT_LONG_CYC;
        endcase
    endfunction

    assign rst_tgt  = rst_cycles(src_q);
    assign wake_tgt = wake_cycles(fz_q.clock_source_select_fuses);
    assign wdt_tgt  = wdt_cycles(sut_q);

    // ----------------------------------------------------------------
    // synchronisers and edge detection
    // ----------------------------------------------------------------
    // two flops for every outside level; a third for edges. no reset, so the
    // edge flops track their pins and no false edge follows reset release
    always_ff @(posedge CLK_I)
    begin
        if (CE_I)
        begin
            osc_s1_q <= {WAKE_I, WDT_OSC_I, CLOCK_INPUT_PIN_I, RC_OSC_I, LF_OSC_I};
            osc_s2_q <= osc_s1_q;
            osc_d_q  <= osc_s2_q[3:0];
        end
    end

    // fuses are quasi-static, still passed through two flops; they keep
    // sampling in reset so the capture after release sees settled fuses
    always_ff @(posedge CLK_I)
    begin
        if (CE_I)
        begin
            fz_s1_q <= FUSE_I;
            fz_q    <= fz_s1_q;
        end
    end

    // selected source edge; per-source history, so a source switch adds no edge
    always_comb
    begin
        unique case (src_q)
            SRC_LF:  src_tick = osc_rise[0];
            SRC_EXT: src_tick = osc_rise[2];
            default: src_tick = osc_rise[1];
        endcase
    end

    assign osc_rise = osc_s2_q[3:0] & ~osc_d_q;
    assign wdt_tick = osc_rise[3];
    assign wake_lvl = osc_s2_q[4];

    // ----------------------------------------------------------------
    // fuse capture: source, start-up code, prescaler preset
    // ----------------------------------------------------------------
    // captured in the idle cycle after reset release
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            src_q      <= SRC_RC;
            sut_q      <= STARTUP_LONG;
            fuse_err_q <= 1'b0;
            DIV_INIT_O <= DIV8_CODE;
        end
        else if (CE_I && state_q == ST_IDLE)
        begin
            // fuse levels are compared with 0 = programmed
            unique case (fz_q.clock_source_select_fuses)
                SEL_LF_FAST, SEL_LF_SLOW: src_q <= SRC_LF;
                SEL_RC:                   src_q <= SRC_RC;
                SEL_EXT:                  src_q <= SRC_EXT;
                default:                  src_q <= SRC_RC;     // reserved code
            endcase
            sut_q      <= fz_q.startup_time_fuses;
            fuse_err_q <= !(fz_q.clock_source_select_fuses inside
                            {SEL_LF_FAST, SEL_LF_SLOW, SEL_RC, SEL_EXT})
                          || (fz_q.startup_time_fuses == 2'h3);
            DIV_INIT_O <= (fz_q.div8_default_fuse == FUSE_PROG) ? DIV8_CODE
                                                                : DIV1_CODE;
        end
    end

    assign SRC_SEL_O = src_q;

    // ----------------------------------------------------------------
    // start-up sequencer
    // ----------------------------------------------------------------
    // next state: src, wdt and wake phases end on the counter reaching its target on a tick; run and sleep leave on sleep and wake requests
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:  state_d = ST_SRC;
            ST_SRC:   if (src_tick && cnt_q == rst_tgt - 17'h1)
                          state_d = (wdt_tgt == 17'h0) ? ST_RUN : ST_WDT;
            ST_WDT:   if (wdt_tick && cnt_q == wdt_tgt - 17'h1)
                          state_d = ST_RUN;
            ST_RUN:   if (sleep_req)
                          state_d = ST_SLEEP;
            ST_SLEEP: if (wake_lvl)
                          state_d = ST_WAKE;
            ST_WAKE:  if (src_tick && cnt_q == wake_tgt - 17'h1)
                          state_d = ST_RUN;
            default:  state_d = ST_IDLE;                       // illegal code
        endcase
    end

    // state and run flag; run set when the next state is ST_RUN, after the last count of the phase
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            state_q <= ST_IDLE;
            RUN_O   <= 1'b0;
        end
        else if (CE_I)
        begin
            state_q <= state_d;
            RUN_O   <= (state_d == ST_RUN);
        end
    end

    // shared counter: source cycles, then watchdog cycles
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            cnt_q <= 17'h0;
        else if (CE_I)
        begin
            if (state_d != state_q)
                cnt_q <= 17'h0;                                // restart per phase
            else if ((state_q == ST_SRC || state_q == ST_WAKE) && src_tick)
                cnt_q <= cnt_q + 17'h1;
            else if (state_q == ST_WDT && wdt_tick)
                cnt_q <= cnt_q + 17'h1;
        end
    end

    // watchdog tick out runs regardless of the selected source
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            WDT_TICK_O <= 1'b0;
        else if (CE_I)
            WDT_TICK_O <= wdt_tick;
    end

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    assign apb_acc   = PSEL_I && PENABLE_I && PREADY_O;
    assign apb_wr    = apb_acc && PWRITE_I;
    assign addr_ok   = (PADDR_I == OFS_TRIM) || (PADDR_I == OFS_CTRL)
                       || (PADDR_I == OFS_STATUS);
    assign sleep_req = apb_wr && (PADDR_I == OFS_CTRL) && PWDATA_I[CTRL_SLEEP_B];

    // one wait state: ready rises one cycle into the access phase
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= RD_ZERO;
        end
        else if (CE_I)
        begin
            PREADY_O  <= PSEL_I && PENABLE_I && !PREADY_O;
            PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && !addr_ok;
            PRDATA_O  <= RD_ZERO;
            if (PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I)
            begin
                unique case (PADDR_I)
                    OFS_TRIM:   PRDATA_O <= {24'h000000, TRIM_O};
                    OFS_STATUS: PRDATA_O <= {21'h000000, state_q, 1'b0,
                                             fuse_err_q, DIV_INIT_O == DIV8_CODE,
                                             sut_q, src_q, RUN_O};
                    default:    PRDATA_O <= RD_ZERO;           // ctrl, unmapped
                endcase
            end
        end
    end

    // trim register: factory value at reset, software after
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            TRIM_O <= FACTORY_TRIM_I;
        else if (CE_I && apb_wr && PADDR_I == OFS_TRIM)
            TRIM_O <= PWDATA_I[7:0];
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    a_lf_select: assert property ((state_q == ST_SRC && (fz_q.clock_source_select_fuses == SEL_LF_FAST
        || fz_q.clock_source_select_fuses == SEL_LF_SLOW)) |-> SRC_SEL_O == SRC_LF)
        else $error("lf code did not select lf source");
    a_rc_select: assert property ((state_q == ST_SRC && fz_q.clock_source_select_fuses == SEL_RC)
        |-> SRC_SEL_O == SRC_RC)
        else $error("rc code did not select rc source");
    a_ext_select: assert property ((state_q == ST_SRC && fz_q.clock_source_select_fuses == SEL_EXT)
        |-> SRC_SEL_O == SRC_EXT)
        else $error("ext code did not select ext input");
    a_src_count: assert property ((CE_I && state_q == ST_SRC && src_tick
        && cnt_q == rst_cycles(src_q) - 17'h1) |=> state_q != ST_SRC)
        else $error("reset source count not honoured");
    a_wake_count: assert property ((CE_I && state_q == ST_WAKE && src_tick && cnt_q
        == wake_cycles(fz_q.clock_source_select_fuses) - 17'h1) |=> RUN_O)
        else $error("wake count did not release run");
    a_wdt_count: assert property ((CE_I && state_q == ST_WDT && sut_q == STARTUP_MID && wdt_tick
        && cnt_q == WDT_MID_CYC - 17'h1) |=> state_q == ST_RUN)
        else $error("watchdog delay length wrong");
    a_trim_load: assert property ($past(SYS_RST_I) |-> TRIM_O == $past(FACTORY_TRIM_I))
        else $error("factory trim not loaded");
    a_trim_write: assert property ((CE_I && apb_wr && PADDR_I == OFS_TRIM)
        |=> TRIM_O == $past(PWDATA_I[7:0]))
        else $error("software trim write lost");
    a_div8_preset: assert property ((state_q == ST_SRC) |-> DIV_INIT_O ==
        ((fz_q.div8_default_fuse == FUSE_PROG) ? DIV8_CODE : DIV1_CODE))
        else $error("prescaler preset wrong");
    a_wdt_tick: assert property ((CE_I && wdt_tick) |=> WDT_TICK_O)
        else $error("watchdog tick dropped");
    a_run_gate: assert property (RUN_O |-> state_q == ST_RUN)
        else $error("run asserted before start-up done");

    c_reset_wdt: cover property (state_q == ST_WDT ##1 state_q == ST_RUN);
    c_reset_short: cover property (state_q == ST_SRC ##1 state_q == ST_RUN);
    c_sleep_wake: cover property (state_q == ST_WAKE ##1 state_q == ST_RUN);
    c_trim_write: cover property (apb_wr && PADDR_I == OFS_TRIM);

endmodule // cssel_top

`default_nettype wire

// file: dv/cssel_osc_model.sv
/*
 * cssel_osc_model: free-running lf crystal, rc, external and watchdog
 * oscillator levels seen at the far side of the clock selector.
 * assumes: the bench wires the levels to the oscillator inputs of cssel_top.
 */
`timescale 1ns/1ps
`default_nettype none

module cssel_osc_model
#(
    parameter int LF_HALF_NS  = 170, // lf crystal half period
    parameter int RC_HALF_NS  = 130, // rc oscillator half period
    parameter int EXT_HALF_NS = 110, // external clock half period
    parameter int WDT_HALF_NS = 120  // watchdog oscillator half period
)
(
    // oscillator levels
    output var logic lf_osc_o,
    output var logic rc_osc_o,
    output var logic ext_osc_o,
    output var logic wdt_osc_o
);
    // ------------------------------------------------------------
    // oscillators: fixed periods, so no cycle-to-cycle frequency jump
    // ------------------------------------------------------------
    initial
    begin
        lf_osc_o = 1'b0;
        #3 forever #(LF_HALF_NS) lf_osc_o = ~lf_osc_o;
    end
    initial
    begin
        rc_osc_o = 1'b0;
        #7 forever #(RC_HALF_NS) rc_osc_o = ~rc_osc_o;
    end
    initial
    begin
        ext_osc_o = 1'b0;
        #11 forever #(EXT_HALF_NS) ext_osc_o = ~ext_osc_o;
    end
    // watchdog keeps running whatever source is chosen
    initial
    begin
        wdt_osc_o = 1'b0;
        #17 forever #(WDT_HALF_NS) wdt_osc_o = ~wdt_osc_o;
    end
endmodule // cssel_osc_model

`default_nettype wire

// file: dv/testbench.sv
/*
 * testbench: fuse table walk through reset start-up, sleep and wake,
 * plus trim register and status access over apb.
 * assumes: cssel_pkg and cssel_top compiled first; oscillator model beside.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import cssel_pkg::*;
    // ------------------------------------------------------------
    // settings
    // ------------------------------------------------------------
    localparam logic [16:0] LF_LONG  = 17'h00010; // shortened long wake
    localparam logic [16:0] WDT_LONG = 17'h00020; // shortened long delay
    localparam int          LIMIT    = 100000;    // cycle ceiling
    localparam logic [3:0]  SELS [5] = '{SEL_RC, SEL_EXT, SEL_LF_FAST, SEL_LF_SLOW, 4'h3};
    localparam logic [1:0]  STFS [5] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h3};
    localparam logic        DIVS [5] = '{FUSE_PROG, 1'b1, 1'b1, 1'b1, FUSE_PROG};
    logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr, wake, tick, run, osc, er;
    logic [7:0]  paddr, trim_f, trim;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  div;
    cssel_fuse_s fuse;
    cssel_src_e  src;
    wire         lf, rc, ext, wdt;
    int          err_total, n_checks, cs, cw, ticks, cyc;

    cssel_top #(.LF_WAKE_LONG_CYC(LF_LONG), .WDT_LONG_CYC(WDT_LONG)) cssel_top_inst (
        .CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .FUSE_I(fuse), .FACTORY_TRIM_I(trim_f),
        .LF_OSC_I(lf), .RC_OSC_I(rc), .CLOCK_INPUT_PIN_I(ext), .WDT_OSC_I(wdt), .WAKE_I(wake),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .SRC_SEL_O(src), .DIV_INIT_O(div), .TRIM_O(trim), .WDT_TICK_O(tick), .RUN_O(run));
    cssel_osc_model cssel_osc_model_inst (.lf_osc_o(lf), .rc_osc_o(rc), .ext_osc_o(ext),
        .wdt_osc_o(wdt));

    // ------------------------------------------------------------
    // clock, edge counters and timeout
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // follow whichever source the fuses pick
    always_comb osc = (fuse.clock_source_select_fuses inside {SEL_LF_FAST, SEL_LF_SLOW}) ? lf :
                      (fuse.clock_source_select_fuses == SEL_EXT) ? ext : rc;
    always @(posedge osc) cs++;
    always @(posedge wdt) cw++;
    always @(posedge clk)
    begin
        cyc++;
        if (tick === 1'b1) ticks++;
        if (cyc == LIMIT) chk(32'h0, 32'h1, "timeout");
        if (cyc == LIMIT) end_sim;
    end

    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wait_run(input int lim);
        int n;
        n = 0;
        while (run !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, run}, 32'h1, "no start-up complete");
    endtask
    function automatic cssel_src_e src_of(input logic [3:0] s);
        if (s == SEL_LF_FAST || s == SEL_LF_SLOW) return SRC_LF;
        return (s == SEL_EXT) ? SRC_EXT : SRC_RC;
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int n, m, w, d;
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        fuse = '{SEL_RC, 2'h2, FUSE_PROG}; trim_f = 8'h40; wake = 1'b0; ce = 1'b1;
        err_total = 0; n_checks = 0; cs = 0; cw = 0; ticks = 0; cyc = 0;
        for (int i = 0; i < 5; i++)
        begin
            // source changes only while reset is held
            @(posedge clk);
            rst <= 1'b1; fuse <= '{SELS[i], STFS[i], DIVS[i]}; trim_f <= 8'h40 + 8'(i);
            repeat (15) @(posedge clk);
            // count from here: the first counted edge may land just before release
            cs = 0;
            cw = 0;
            @(posedge clk);
            chk({24'h0, trim}, {24'h0, trim_f}, "trim reload");
            n = (src_of(SELS[i]) == SRC_LF) ? int'(LF_RST_CYC) : int'(RC_RST_CYC);
            m = (STFS[i] == 2'h0) ? 0 : (STFS[i] == 2'h1) ? int'(WDT_MID_CYC) : int'(WDT_LONG);
            w = (SELS[i] == SEL_LF_FAST) ? int'(LF_WAKE_CYC) :
                (SELS[i] == SEL_LF_SLOW) ? int'(LF_LONG) : int'(RC_WAKE_CYC);
            rst <= 1'b0;
            wait_run(30000);
            if (m == 0) chk({31'h0, cs >= n && cs <= n + 1}, 32'h1, "reset count");
            else chk({31'h0, cw >= m && cw <= m + 24}, 32'h1, "watchdog delay");
            chk({30'h0, src}, {30'h0, src_of(SELS[i])}, "source");
            chk({28'h0, div}, {28'h0, DIVS[i] == FUSE_PROG ? DIV8_CODE : DIV1_CODE}, "div");
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(rd & 32'h000007ff, {21'h0, 3'b011, 1'b0, i == 4, DIVS[i] == FUSE_PROG, STFS[i],
                src_of(SELS[i]), 1'b1}, "status");
            apb(1'b1, OFS_TRIM, {24'h0, 8'hc0 + 8'(i)});
            apb(1'b0, OFS_TRIM, 32'h0);
            chk(rd, {24'h0, 8'hc0 + 8'(i)}, "trim readback");
            chk({24'h0, trim}, {24'h0, 8'hc0 + 8'(i)}, "trim out");
            // sleep, then wake on the chosen source's own cycles
            apb(1'b1, OFS_CTRL, 32'h1);
            repeat (3) @(posedge clk);
            chk({31'h0, run}, 32'h0, "sleep");
            wake <= 1'b1;
            cs = 0;
            wait_run(20000);
            wake <= 1'b0;
            chk({31'h0, cs >= w && cs <= w + 2}, 32'h1, "wake count");
        end
        // unmapped place: refused, write ignored
        apb(1'b1, 8'h0c, 32'h000000ff);
        chk({31'h0, er}, 32'h1, "unmapped write");
        apb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped read");
        chk(rd, RD_ZERO, "unmapped data");
        chk({24'h0, trim}, 32'h000000c4, "trim kept");
        // watchdog ticks keep pace with its oscillator
        d = cw;
        ticks = 0;
        repeat (400) @(posedge clk);
        d = ticks - (cw - d);
        chk({31'h0, d >= -1 && d <= 1}, 32'h1, "watchdog ticks");
        // clock enable low: tick and run must stay frozen
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        er = tick;
        n = 0;
        repeat (40)
        begin
            @(posedge clk);
            n += (tick !== er || run !== 1'b1);
        end
        chk(n, 32'h0, "clock enable freeze");
        ce <= 1'b1;
        end_sim;
    end
endmodule // testbench

`default_nettype wire
